// >>> host_port.sv
`timescale 1ns/1ps
module host_port (
    input  wire logic       mclk,       // clock
    input  wire logic       rd_ready,   // read taken
    input  wire logic       rd_valid,   // byte present
    input  wire logic [7:0] rd_data,    // read byte
    output logic            addr_load,  // pointer load
    output logic [7:0]      addr_value, // pointer value
    output logic            wr_req,     // write strobe
    output logic [7:0]      wr_data,    // write byte
    output logic            rd_req,     // read request
    output logic            rd_accept,  // take byte
    output logic            stop_seen   // i2c stop
);
    logic [7:0] got[$];
    bit         slow = 1'b0;
    initial
    begin
        {addr_load, wr_req, rd_req, rd_accept, stop_seen} = 5'h00;
        addr_value = 8'h00;
        wr_data = 8'h00;
    end
    task automatic ld(input logic [7:0] a);
        @(negedge mclk);
        addr_load = 1'b1;
        addr_value = a;
        @(negedge mclk);
        addr_load = 1'b0;
    endtask : ld
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        ld(a);
        wr_req = 1'b1;
        wr_data = d;
        @(negedge mclk);
        wr_req = 1'b0;
    endtask : wr
    // ascending burst keeps each high byte ahead of its low byte
    task automatic rd(input logic [7:0] a, input int n, input bit load);
        int tk;
        tk = 0;
        got.delete();
        if (load)
            ld(a);
        for (int k = 0; k < 300 && got.size() < n; k++)
        begin
            @(negedge mclk);
            // slow host stalls two cycles in three to fill the buffer
            rd_accept = !slow || (k % 3 == 2);
            if (rd_valid && rd_accept)
                got.push_back(rd_data);
            rd_req = tk < n;
            if (rd_req && rd_ready)
                tk++;
        end
    endtask : rd
    task automatic stop();
        @(negedge mclk);
        stop_seen = 1'b1;
        @(negedge mclk);
        stop_seen = 1'b0;
    endtask : stop
endmodule : host_port

// >>> motion_sensor_status_readout.sv
`timescale 1ns/1ps
module motion_sensor_status_readout
    import sensor_regs_pkg::*;
(
    input  wire logic        mclk,              // 40 MHz clock
    input  wire logic        reset,             // sync, active high
    input  wire logic        port_is_spi,       // 1: spi port, 0: i2c
    input  wire logic        addr_load,         // pulse: load pointer
    input  wire logic [7:0]  addr_value,        // pointer value to load
    input  wire logic        wr_req,            // pulse: write byte at pointer
    input  wire logic [7:0]  wr_data,           // byte to write
    input  wire logic        rd_req,            // read byte at pointer
    input  wire logic        stop_seen,         // pulse: i2c stop condition
    output logic             rd_ready,          // read request can be taken
    output logic             rd_valid,          // read byte available
    output logic [7:0]       rd_data,           // read byte
    input  wire logic        rd_accept,         // host takes read byte
    input  wire logic [1:0]  fifo_mode,         // fifo operating mode
    input  wire logic [7:0]  fifo_status,       // fifo status byte
    input  wire logic [2:0]  acc_sample_valid,  // pulse per axis: z,y,x
    input  wire logic [13:0] acc_x,             // x acceleration sample
    input  wire logic [13:0] acc_y,             // y acceleration sample
    input  wire logic [13:0] acc_z,             // z acceleration sample
    input  wire logic        mag_sample_valid,  // pulse: new magnetic set
    input  wire logic [15:0] mag_x,             // x magnetic sample
    input  wire logic [15:0] mag_y,             // y magnetic sample
    input  wire logic [15:0] mag_z,             // z magnetic sample
    output logic             active,            // sampling enabled
    output logic [2:0]       output_rate_select,// output data rate
    output logic [1:0]       sleep_rate,        // sleep-state rate
    output logic             low_noise,         // low-noise mode
    output logic             fast_read,         // 8-bit read mode
    output logic [1:0]       sensor_select,     // 11 hybrid
    output logic [2:0]       magnetic_oversample_ratio, // oversampling
    output logic             auto_cal,          // auto calibration
    output logic             mag_reset_pulse,   // one-shot magnetic reset
    output logic             mag_oneshot_pulse, // one-shot measurement
    output logic             hyb_autoinc,       // magnetic after accel
    output logic             maxmin_disable,    // min/max latching off
    output logic             maxmin_ths_disable,// threshold variant off
    output logic             maxmin_reset,      // reset min/max
    output logic [1:0]       mag_reset_count,   // magnetic reset interval
    output logic [1:0]       full_scale_select, // accel full scale
    output logic             hpf_out            // high-pass data to outputs
);

    logic [7:0]  ptr_q;
    logic [7:0]  ptr_d;
    logic [7:0]  accel_control_first_q;
    logic [7:0]  magnetic_control_first_q;
    logic [7:0]  magnetic_control_second_q;
    logic [7:0]  accel_data_config_q;
    logic [2:0]  rdy_q;
    logic [2:0]  ow_q;
    logic        zyxdr_q;
    logic        zyxow_q;
    logic [2:0]  seen_q;
    logic [15:0] acc_q [3];
    logic [15:0] mag_q [3];
    logic [7:0]  lsb_q [6];
    logic        out_valid_q;
    logic [7:0]  out_data_q;
    logic        spare_valid_q;
    logic [7:0]  spare_data_q;
    logic        room_q;
    logic        mrst_q;
    logic        most_q;

    wire        is_active  = accel_control_first_q[CTRL1_ACTIVE_BIT];
    wire        hyb_on     = magnetic_control_second_q[MCTRL2_HYB_BIT];
    wire        fread_on   = accel_control_first_q[CTRL1_FREAD_BIT];
    wire        rd_take    = rd_req && !spare_valid_q;
    wire        wr_take    = wr_req && !addr_load;
    wire        access     = rd_take || wr_take;
    wire        ctrl1_wr   = wr_take && ptr_q == CTRL1_ADDR;
    wire        mctrl1_wr  = wr_take && ptr_q == MCTRL1_ADDR;
    wire        mctrl2_wr  = wr_take && ptr_q == MCTRL2_ADDR;
    wire        dcfg_wr    = wr_take && ptr_q == DATA_CFG_ADDR;
    // entering standby clears all stale status
    wire        to_standby = ctrl1_wr && is_active
                             && !wr_data[CTRL1_ACTIVE_BIT];
    wire [13:0] acc_in [3];
    wire [15:0] mag_in [3];
    wire [2:0]  msb_rd;
    wire [2:0]  new_ow;
    wire [2:0]  sample;
    wire        all_seen;
    wire        any_sample;
    wire [7:0]  status_byte;
    wire [7:0]  alias_byte;
    wire [7:0]  data_byte;
    wire [7:0]  rd_byte;
    wire        acc_hit;
    wire        mag_hit;
    wire [7:0]  acc_off;
    wire [7:0]  mag_off;
    wire [7:0]  ptr_inc;

    assign acc_in[0] = acc_x;
    assign acc_in[1] = acc_y;
    assign acc_in[2] = acc_z;
    assign mag_in[0] = mag_x;
    assign mag_in[1] = mag_y;
    assign mag_in[2] = mag_z;

    // samples are ignored in standby so flags stay clear there
    assign sample = acc_sample_valid & {3{is_active}};

    genvar i;
    generate
        for (i = 0; i < 3; i++)
        begin : g_axis
            // a taken read at this axis' high-byte address
            assign msb_rd[i] = rd_take
                && ptr_q == ACC_X_MSB_ADDR + 8'(2 * i);
            assign new_ow[i] = sample[i] && rdy_q[i];

            always_ff @(posedge mclk)
            begin
                if (reset || to_standby)
                begin
                    rdy_q[i] <= 1'b0;
                    ow_q[i] <= 1'b0;
                end
                else
                begin
                    // a new sample in the clearing cycle still wins
                    rdy_q[i] <= sample[i]
                        || (rdy_q[i] && !msb_rd[i]);
                    ow_q[i] <= new_ow[i]
                        || (ow_q[i] && !msb_rd[i]);
                end
            end

            // left justified 14-bit accel data
            always_ff @(posedge mclk)
            begin
                if (reset)
                    acc_q[i] <= 16'h0000;
                else if (sample[i])
                    acc_q[i] <= {acc_in[i], {ACC_PAD{1'b0}}};
            end

            always_ff @(posedge mclk)
            begin
                if (reset)
                    mag_q[i] <= 16'h0000;
                else if (mag_sample_valid && is_active)
                    mag_q[i] <= mag_in[i];
            end

            // low byte frozen at high-byte read so the pair is coherent
            always_ff @(posedge mclk)
            begin
                if (reset)
                begin
                    lsb_q[i]     <= 8'h00;
                    lsb_q[i + 3] <= 8'h00;
                end
                else
                begin
                    if (msb_rd[i])
                        lsb_q[i] <= acc_q[i][7:0];
                    if (rd_take
                        && ptr_q == MAG_X_MSB_ADDR + 8'(2 * i))
                        lsb_q[i + 3] <= mag_q[i][7:0];
                end
            end
        end
    endgenerate

    assign any_sample = |sample;
    // seen_q: high bytes read since the last combined clear
    assign all_seen   = &(seen_q | msb_rd);

    always_ff @(posedge mclk)
    begin
        if (reset || to_standby)
        begin
            zyxdr_q <= 1'b0;
            zyxow_q <= 1'b0;
            seen_q  <= 3'b000;
        end
        else
        begin
            // set wins over the all-read clear
            zyxdr_q <= any_sample
                || (zyxdr_q && !all_seen);
            zyxow_q <= (any_sample && zyxdr_q)
                || (zyxow_q && !all_seen);
            seen_q  <= all_seen ? 3'b000 : (seen_q | msb_rd);
        end
    end

    assign status_byte = {zyxow_q, ow_q[2], ow_q[1], ow_q[0],
                          zyxdr_q, rdy_q[2], rdy_q[1], rdy_q[0]};
    assign alias_byte  = (fifo_mode == FIFO_MODE_OFF)
                         ? status_byte : fifo_status;

    assign acc_hit = ptr_q >= ACC_X_MSB_ADDR && ptr_q <= ACC_Z_LSB_ADDR;
    assign mag_hit = ptr_q >= MAG_X_MSB_ADDR && ptr_q <= MAG_Z_LSB_ADDR;
    assign acc_off = ptr_q - ACC_X_MSB_ADDR;
    assign mag_off = ptr_q - MAG_X_MSB_ADDR;

    // high byte live, low byte from the snapshot
    assign data_byte =
        acc_hit ? (acc_off[0] ? lsb_q[acc_off[2:1]]
                              : acc_q[acc_off[2:1]][15:8])
      : mag_hit ? (mag_off[0] ? lsb_q[3 + mag_off[2:1]]
                              : mag_q[mag_off[2:1]][15:8])
      : 8'h00;

    // unmapped addresses read back as zero
    assign rd_byte =
        ptr_q == STATUS_ADDR   ? alias_byte
      : ptr_q == CTRL1_ADDR    ? accel_control_first_q
      : ptr_q == MCTRL1_ADDR   ? magnetic_control_first_q
      : ptr_q == MCTRL2_ADDR   ? magnetic_control_second_q
      : ptr_q == DATA_CFG_ADDR ? accel_data_config_q
      : ptr_q == IDENT_ADDR    ? IDENT_VALUE
      : data_byte;

    // status alias runs straight into the sample bytes
    assign ptr_inc =
        (fread_on && acc_hit && !acc_off[0]
            && ptr_q != ACC_Z_LSB_ADDR - 8'h01)
            ? ptr_q + 8'h02
      : (fread_on && ptr_q == ACC_Z_LSB_ADDR - 8'h01)
            ? (hyb_on ? MAG_X_MSB_ADDR : STATUS_ADDR)
      : (hyb_on && ptr_q == ACC_Z_LSB_ADDR) ? MAG_X_MSB_ADDR
      : (hyb_on && ptr_q == MAG_Z_LSB_ADDR) ? STATUS_ADDR
      : ptr_q + 8'h01;

    // a pointer load outranks the stop return
    assign ptr_d =
        addr_load                   ? addr_value
      : (stop_seen && !port_is_spi) ? STATUS_ADDR
      : access                      ? ptr_inc
      : ptr_q;

    always_ff @(posedge mclk)
    begin
        if (reset)
            ptr_q <= STATUS_ADDR;
        else
            ptr_q <= ptr_d;
    end

    // active may be dropped at any time; the rest only from standby
    always_ff @(posedge mclk)
    begin
        if (reset)
            accel_control_first_q <= CTRL1_RESET;
        else if (ctrl1_wr && !is_active)
            accel_control_first_q <= wr_data;
        else if (ctrl1_wr)
            accel_control_first_q[CTRL1_ACTIVE_BIT]
                <= wr_data[CTRL1_ACTIVE_BIT];
    end

    // one-shot bits never store; they fire a single-cycle pulse
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            magnetic_control_first_q <= MCTRL1_RESET;
            mrst_q                   <= 1'b0;
            most_q                   <= 1'b0;
        end
        else
        begin
            mrst_q <= mctrl1_wr && !is_active
                      && wr_data[MCTRL1_RST_BIT];
            most_q <= mctrl1_wr && !is_active
                      && wr_data[MCTRL1_OST_BIT];
            if (mctrl1_wr && !is_active)
            begin
                magnetic_control_first_q <= wr_data;
                magnetic_control_first_q[MCTRL1_RST_BIT] <= 1'b0;
                magnetic_control_first_q[MCTRL1_OST_BIT] <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
            magnetic_control_second_q <= MCTRL2_RESET;
        else if (mctrl2_wr && !is_active)
            magnetic_control_second_q <= wr_data;
    end

    // full scale may change while active, other fields may not
    always_ff @(posedge mclk)
    begin
        if (reset)
            accel_data_config_q <= DATA_CFG_RESET;
        else if (dcfg_wr && !is_active)
            accel_data_config_q <= wr_data;
        else if (dcfg_wr)
            accel_data_config_q <= (accel_data_config_q & ~DCFG_SCALE_MASK)
                | (wr_data & DCFG_SCALE_MASK);
    end

    // two-entry skid buffer: host stall never drops a byte
    wire take_out = !out_valid_q || rd_accept;

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            out_valid_q   <= 1'b0;
            spare_valid_q <= 1'b0;
            room_q        <= 1'b1;
        end
        // ready has its own flop, always the mirror of an empty spare
        else if (take_out)
        begin
            out_valid_q   <= spare_valid_q || rd_take;
            spare_valid_q <= spare_valid_q && rd_take;
            room_q        <= !(spare_valid_q && rd_take);
        end
        else if (rd_take)
        begin
            spare_valid_q <= 1'b1;
            room_q        <= 1'b0;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            out_data_q   <= 8'h00;
            spare_data_q <= 8'h00;
        end
        else
        begin
            if (take_out)
                out_data_q <= spare_valid_q ? spare_data_q : rd_byte;
            if (rd_take && (spare_valid_q || !take_out))
                spare_data_q <= rd_byte;
        end
    end

    assign rd_ready    = room_q;
    assign rd_valid    = out_valid_q;
    assign rd_data     = out_data_q;

    assign active             = accel_control_first_q[CTRL1_ACTIVE_BIT];
    assign output_rate_select =
        accel_control_first_q[CTRL1_RATE_LSB +: 3];
    assign sleep_rate         = accel_control_first_q[CTRL1_ASLP_LSB +: 2];
    assign low_noise          =
        accel_control_first_q[CTRL1_LNOISE_BIT];
    assign fast_read          = accel_control_first_q[CTRL1_FREAD_BIT];
    assign sensor_select      =
        magnetic_control_first_q[MCTRL1_HMS_LSB +: 2];
    assign magnetic_oversample_ratio =
        magnetic_control_first_q[MCTRL1_OS_LSB +: 3];
    assign auto_cal           = magnetic_control_first_q[MCTRL1_ACAL_BIT];
    assign mag_reset_pulse    = mrst_q;
    assign mag_oneshot_pulse  = most_q;
    assign hyb_autoinc        = magnetic_control_second_q[MCTRL2_HYB_BIT];
    assign maxmin_disable     = magnetic_control_second_q[MCTRL2_MMDIS_BIT];
    assign maxmin_ths_disable = magnetic_control_second_q[MCTRL2_MMTHS_BIT];
    assign maxmin_reset       = magnetic_control_second_q[MCTRL2_MMRST_BIT];
    assign mag_reset_count    =
        magnetic_control_second_q[MCTRL2_CNT_LSB +: 2];
    assign full_scale_select  = accel_data_config_q[DCFG_SCALE_LSB +: 2];
    assign hpf_out            = accel_data_config_q[DCFG_HPF_BIT];

endmodule : motion_sensor_status_readout

// >>> motion_sensor_status_readout_checker.sv
`timescale 1ns/1ps
module readout_checker (
    input wire logic       mclk,               // clock
    input wire logic       reset,              // sync reset
    input wire logic       wr_req,             // write strobe
    input wire logic [7:0] wr_data,            // write byte
    input wire logic       rd_req,             // read request
    input wire logic       rd_ready,           // read taken
    input wire logic       rd_valid,           // byte present
    input wire logic [7:0] rd_data,            // read byte
    input wire logic       rd_accept,          // host takes byte
    input wire logic       active,             // sampling on
    input wire logic [2:0] output_rate_select, // rate
    input wire logic       low_noise,          // low noise
    input wire logic [1:0] sensor_select,      // sensors
    input wire logic [2:0] magnetic_oversample_ratio, // oversampling
    input wire logic       hyb_autoinc,        // hybrid map
    input wire logic [1:0] full_scale_select,  // full scale
    input wire logic       mag_reset_pulse,    // one-shot reset
    input wire logic       mag_oneshot_pulse   // one-shot read
);
    logic [1:0] scale_wr;
    assign scale_wr = wr_data[1:0];
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    sequence take_s;
        rd_req && rd_ready && !rd_valid;
    endsequence
    sequence stall_s;
        rd_valid && !rd_accept;
    endsequence
    property one_cycle_p(p);
        p |=> !p;
    endproperty
    rd_answer_a: assert property (take_s |=> rd_valid)
        else $error("taken read gave no byte");
    rd_hold_a: assert property (
        stall_s |=> rd_valid && $stable(rd_data))
        else $error("unaccepted byte changed");
    ready_hold_a: assert property (
        !rd_ready && !rd_accept |=> !rd_ready)
        else $error("full buffer took a read");
    rst_idle_a: assert property (
        $fell(reset) |-> rd_ready && !rd_valid && !active)
        else $error("not idle after reset");
    active_cfg_a: assert property (active && $past(active) |->
        $stable(output_rate_select) && $stable(low_noise)
        && $stable(sensor_select)
        && $stable(magnetic_oversample_ratio) && $stable(hyb_autoinc))
        else $error("config changed while active");
    active_cause_a: assert property (
        $changed(active) |-> $past(wr_req))
        else $error("active changed without write");
    scale_cause_a: assert property ($changed(full_scale_select) |->
        $past(wr_req) && $past(scale_wr) == full_scale_select)
        else $error("full scale differs from write");
    shot_once_a: assert property (one_cycle_p(mag_oneshot_pulse))
        else $error("one-shot pulse too long");
    mrst_once_a: assert property (one_cycle_p(mag_reset_pulse))
        else $error("reset pulse too long");
    shot_cause_a: assert property ($rose(mag_oneshot_pulse) |->
        !active && ($past(wr_req) || $past(wr_req, 2)))
        else $error("one-shot pulse without write");
endmodule : readout_checker
bind motion_sensor_status_readout readout_checker chk (.*);

// >>> motion_sensor_status_readout_tb_top.sv
`timescale 1ns/1ps
module motion_sensor_status_readout_tb_top
    import sensor_regs_pkg::*;
;
    logic mclk = 1'b0, reset = 1'b1, port_is_spi = 1'b0;
    logic mag_sample_valid = 1'b0;
    logic [1:0] fifo_mode = 2'b00;
    logic [7:0] fifo_status = 8'h00;
    logic [2:0] acc_sample_valid = 3'h0;
    logic [13:0] acc_x = 14'h1235, acc_y = 14'h2abc, acc_z = 14'h3f01;
    logic [15:0] mag_x = 16'h8001, mag_y = 16'h7ffe, mag_z = 16'h0c3a;
    logic addr_load, wr_req, rd_req, stop_seen, rd_ready, rd_valid, rd_accept;
    logic [7:0] addr_value, wr_data, rd_data;
    logic active, low_noise, fast_read, auto_cal, mag_reset_pulse, hpf_out;
    logic mag_oneshot_pulse, hyb_autoinc, maxmin_disable, maxmin_ths_disable;
    logic maxmin_reset;
    logic [2:0] output_rate_select, magnetic_oversample_ratio;
    logic [1:0] sleep_rate, sensor_select, mag_reset_count, full_scale_select;
    int err_total = 0;
    int tests_run = 0;
    int cycles = 0;
    motion_sensor_status_readout DUT (.*);
    host_port h (.*);
    always #12.5 mclk = ~mclk;
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_total++;
            stop_test();
        end
    end
    task automatic check(string nm, logic [15:0] e, logic [15:0] g);
        tests_run++;
        if (g !== e)
        begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : check
    task automatic chk_rd(string nm, logic [7:0] a, logic [7:0] e);
        h.rd(a, 1, 1'b1);
        check(nm, {8'h00, e}, {8'h00, h.got[0]});
    endtask : chk_rd
    task automatic smp(logic [2:0] b, logic m);
        @(negedge mclk);
        acc_sample_valid = b;
        mag_sample_valid = m;
        @(negedge mclk);
        acc_sample_valid = 3'h0;
        mag_sample_valid = 1'b0;
    endtask : smp
    task automatic t_reset();
        smp(3'h7, 1'b1);
        chk_rd("status", STATUS_ADDR, 8'h00);
        chk_rd("ctrl1", CTRL1_ADDR, CTRL1_RESET);
        chk_rd("mctrl1", MCTRL1_ADDR, MCTRL1_RESET);
        chk_rd("mctrl2", MCTRL2_ADDR, MCTRL2_RESET);
        chk_rd("dcfg", DATA_CFG_ADDR, DATA_CFG_RESET);
        chk_rd("ident", IDENT_ADDR, IDENT_VALUE);
        chk_rd("unmapped", 8'h7f, 8'h00);
        $display("t_reset done");
    endtask : t_reset
    task automatic t_config();
        h.wr(CTRL1_ADDR, 8'h00);
        h.wr(MCTRL1_ADDR, 8'h7f);
        h.wr(MCTRL2_ADDR, 8'h20);
        h.wr(DATA_CFG_ADDR, 8'h01);
        h.wr(CTRL1_ADDR, 8'h0d);
        h.wr(MCTRL1_ADDR, 8'h00);
        chk_rd("mctrl1", MCTRL1_ADDR, 8'h1f);
        check("accel", 16'h0026, {10'h0, active, output_rate_select,
            low_noise, fast_read});
        check("magnetic", 16'h003f, {9'h0, sensor_select, hyb_autoinc,
            magnetic_oversample_ratio});
        check("misc", 16'h0000, {7'h00, sleep_rate, auto_cal, hpf_out,
            maxmin_disable, maxmin_ths_disable, maxmin_reset,
            mag_reset_count});
        h.wr(DATA_CFG_ADDR, 8'h02);
        check("fs active", 16'h0002, {14'h0, full_scale_select});
        h.wr(DATA_CFG_ADDR, 8'h01);
        check("fs", 16'h0001, {14'h0, full_scale_select});
        $display("t_config done");
    endtask : t_config
    task automatic t_burst();
        logic [103:0] e;
        smp(3'b001, 1'b0);
        smp(3'b001, 1'b0);
        smp(3'b110, 1'b1);
        chk_rd("status", STATUS_ADDR,
            8'h9f);
        e = {8'h9f, acc_x, 2'b00, acc_y, 2'b00, acc_z, 2'b00,
            mag_x, mag_y, mag_z};
        h.slow = 1'b1;
        h.rd(STATUS_ADDR, 13, 1'b1);
        h.slow = 1'b0;
        for (int i = 0; i < 13; i++)
            check("burst", {8'h00, e[103 - 8 * i -: 8]},
                {8'h00, h.got[i]});
        chk_rd("status clr", STATUS_ADDR,
            8'h00);
        $display("t_burst done");
    endtask : t_burst
    task automatic t_pointer();
        smp(3'b001, 1'b0);
        port_is_spi = 1'b1;
        chk_rd("x msb", 8'h01, acc_x[13:6]);
        h.stop();
        h.rd(8'h00, 1, 1'b0);
        check("spi next", {8'h00, acc_x[5:0], 2'b00},
            {8'h00, h.got[0]});
        port_is_spi = 1'b0;
        h.rd(8'h01, 1, 1'b1);
        h.stop();
        h.rd(8'h00, 1, 1'b0);
        check("i2c stop", 16'h0008, {8'h00, h.got[0]});
        h.rd(8'h03, 3, 1'b1);
        chk_rd("all high", STATUS_ADDR, 8'h00);
        $display("t_pointer done");
    endtask : t_pointer
    task automatic t_fifo();
        smp(3'b010, 1'b0);
        fifo_status = 8'ha5;
        fifo_mode = 2'b10;
        chk_rd("fifo alias", STATUS_ADDR, 8'ha5);
        fifo_mode = 2'b00;
        chk_rd("axis alias", STATUS_ADDR, 8'h0a);
        $display("t_fifo done");
    endtask : t_fifo
    task automatic t_fast();
        logic [79:0] e;
        h.wr(CTRL1_ADDR, 8'h00);
        h.wr(MCTRL1_ADDR, 8'h9f);
        h.wr(MCTRL2_ADDR, 8'h3f);
        h.wr(DATA_CFG_ADDR, 8'h11);
        h.wr(CTRL1_ADDR, 8'hc3);
        check("misc set", 16'h01ff, {7'h00, sleep_rate, auto_cal, hpf_out,
            maxmin_disable, maxmin_ths_disable, maxmin_reset,
            mag_reset_count});
        smp(3'h7, 1'b1);
        e = {8'h0f, acc_x[13:6], acc_y[13:6], acc_z[13:6],
            mag_x, mag_y, mag_z};
        h.rd(STATUS_ADDR, 10, 1'b1);
        for (int i = 0; i < 10; i++)
            check("fast", {8'h00, e[79 - 8 * i -: 8]},
                {8'h00, h.got[i]});
        chk_rd("fast clr", STATUS_ADDR, 8'h00);
        $display("t_fast done");
    endtask : t_fast
    task automatic t_standby();
        smp(3'b100, 1'b0);
        h.wr(CTRL1_ADDR, 8'h0c);
        smp(3'b111, 1'b0);
        chk_rd("standby", STATUS_ADDR, 8'h00);
        check("active", 16'h0000, {15'h0, active});
        $display("t_standby done");
    endtask : t_standby
    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : stop_test
    initial
    begin
        repeat (5) @(negedge mclk);
        reset = 1'b0;
        t_reset();
        t_config();
        t_burst();
        t_pointer();
        t_fifo();
        t_fast();
        t_standby();
        stop_test();
    end
endmodule : motion_sensor_status_readout_tb_top

// >>> sensor_regs_pkg.sv
package sensor_regs_pkg;

    localparam logic [7:0] STATUS_ADDR    = 8'h00;
    localparam logic [7:0] ACC_X_MSB_ADDR = 8'h01;
    localparam logic [7:0] ACC_Z_LSB_ADDR = 8'h06;
    localparam logic [7:0] IDENT_ADDR     = 8'h0d;
    localparam logic [7:0] DATA_CFG_ADDR  = 8'h0e;
    localparam logic [7:0] CTRL1_ADDR     = 8'h2a;
    localparam logic [7:0] MAG_X_MSB_ADDR = 8'h33;
    localparam logic [7:0] MAG_Z_LSB_ADDR = 8'h38;
    localparam logic [7:0] MCTRL1_ADDR    = 8'h5b;
    localparam logic [7:0] MCTRL2_ADDR    = 8'h5c;

    // arbitrary neutral value
    localparam logic [7:0] IDENT_VALUE    = 8'h5a;

    localparam logic [7:0] CTRL1_RESET    = 8'h00;
    localparam logic [7:0] MCTRL1_RESET   = 8'h00;
    localparam logic [7:0] MCTRL2_RESET   = 8'h00;
    localparam logic [7:0] DATA_CFG_RESET = 8'h00;

    localparam int CTRL1_ACTIVE_BIT = 0;
    localparam int CTRL1_FREAD_BIT  = 1;
    localparam int CTRL1_LNOISE_BIT = 2;
    localparam int CTRL1_RATE_LSB   = 3;
    localparam int CTRL1_ASLP_LSB   = 6;
    localparam int MCTRL1_HMS_LSB   = 0;
    localparam int MCTRL1_OS_LSB    = 2;
    localparam int MCTRL1_OST_BIT   = 5;
    localparam int MCTRL1_RST_BIT   = 6;
    localparam int MCTRL1_ACAL_BIT  = 7;
    localparam int MCTRL2_CNT_LSB   = 0;
    localparam int MCTRL2_MMRST_BIT = 2;
    localparam int MCTRL2_MMTHS_BIT = 3;
    localparam int MCTRL2_MMDIS_BIT = 4;
    localparam int MCTRL2_HYB_BIT   = 5;
    localparam int DCFG_SCALE_LSB   = 0;
    localparam int DCFG_HPF_BIT     = 4;
    localparam logic [7:0] DCFG_SCALE_MASK = 8'h03;

    localparam logic [1:0] FIFO_MODE_OFF = 2'b00;
    localparam int ACC_PAD = 2;

endpackage : sensor_regs_pkg
